/* File: design/itw_watchdog.sv */
module itw_watchdog #(
    parameter logic [31:0] RELOAD_VALUE = itw_pkg::WDOG_RELOAD,
    parameter bit READABLE_CAPTURE = 1'b0
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic nrst_in,
    // Register port
    input wire itw_pkg::itw_bus_req_t bus_req_in,
    output logic [15:0] rdata_out,
    // Events
    output logic irq_out,
    output logic reset_req_out
);
    import itw_pkg::*;

    // ********************************
    // Counter
    // ********************************

    itw_state_t st;
    itw_state_t next_st;
    logic [31:0] count;
    logic zero;
    logic hit;
    logic wr_status;
    logic wr_control;
    logic wr_reload;
    logic wr_capture;
    logic rd;

    // Bus strobes per register
    assign rd = bus_req_in.rd;
    assign wr_status = bus_req_in.wr && bus_req_in.addr == OFS_STATUS;
    assign wr_control = bus_req_in.wr && bus_req_in.addr == OFS_CONTROL;
    assign wr_reload = bus_req_in.wr && (bus_req_in.addr == OFS_RELOAD_LO
        || bus_req_in.addr == OFS_RELOAD_HI);
    assign wr_capture = bus_req_in.wr && (bus_req_in.addr == OFS_CAPTURE_LO
        || bus_req_in.addr == OFS_CAPTURE_HI);

    // Timeout event: running counter sitting at zero
    assign hit = (st.run == ITW_RUNNING) && zero;

    itw_down_counter #(
        .RELOAD_VALUE(RELOAD_VALUE)
    ) u_counter (
        .core_clk_in(core_clk_in),
        .nrst_in(nrst_in),
        .run_in(st.run == ITW_RUNNING),
        .reload_in(wr_reload),
        .count_out(count),
        .zero_out(zero)
    );

    // ********************************
    // Control and status
    // ********************************

    // Next state of the register file and event outputs
    always_comb begin
        next_st = st;
        // Start only; stop bit has no effect so it can't be halted
        if (wr_control && bus_req_in.wdata[BIT_START]) begin
            next_st.run = ITW_RUNNING;
        end
        if (wr_control) begin
            next_st.interrupt_on_timeout_enable =
                bus_req_in.wdata[BIT_IRQ_ENABLE];
            next_st.continuous_select =
                bus_req_in.wdata[BIT_CONTINUOUS];
        end
        // Clear on status write with bit 0 clear, but a same-cycle timeout wins
        if (wr_status && !bus_req_in.wdata[BIT_TIMEOUT_FLAG]) begin
            next_st.timeout_flag = 1'b0;
        end
        if (hit) begin
            next_st.timeout_flag = 1'b1;
        end
        // Capture does not touch the counter itself
        if (wr_capture) begin
            next_st.capture = count;
        end
        next_st.reset_req = hit;
        next_st.irq = next_st.timeout_flag
            && next_st.interrupt_on_timeout_enable;
        // Registered read data, one cycle after the strobe
        next_st.rdata = RST_RDATA;
        if (rd) begin
            case (bus_req_in.addr)
                OFS_STATUS: begin
                    next_st.rdata[BIT_TIMEOUT_FLAG] = st.timeout_flag;
                    next_st.rdata[BIT_RUNNING] =
                        (st.run == ITW_RUNNING);
                end
                OFS_CONTROL: begin
                    next_st.rdata[BIT_IRQ_ENABLE] =
                        st.interrupt_on_timeout_enable;
                    next_st.rdata[BIT_CONTINUOUS] = st.continuous_select;
                end
                OFS_RELOAD_LO: begin
                    next_st.rdata = RELOAD_VALUE[HALF_W-1:0];
                end
                OFS_RELOAD_HI: begin
                    next_st.rdata = RELOAD_VALUE[2*HALF_W-1:HALF_W];
                end
                OFS_CAPTURE_LO: begin
                    // Hidden in the watchdog build, reads give zero
                    if (READABLE_CAPTURE) begin
                        next_st.rdata = st.capture[HALF_W-1:0];
                    end
                end
                OFS_CAPTURE_HI: begin
                    if (READABLE_CAPTURE) begin
                        next_st.rdata = st.capture[2*HALF_W-1:HALF_W];
                    end
                end
                default: begin
                    next_st.rdata = RST_RDATA;
                end
            endcase
        end
    end

    // State register; stopped after reset
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st.run <= ITW_STOPPED;
            st.timeout_flag <= 1'b0;
            st.interrupt_on_timeout_enable <= 1'b0;
            st.continuous_select <= 1'b0;
            st.capture <= RST_CAPTURE;
            st.rdata <= RST_RDATA;
            st.irq <= 1'b0;
            st.reset_req <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from flops
    assign rdata_out = st.rdata;
    assign irq_out = st.irq;
    assign reset_req_out = st.reset_req;

    // ********************************
    // Checks
    // ********************************

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);

    sequence s_timeout;
        (st.run == ITW_RUNNING) && zero;
    endsequence

    sequence s_one_pulse;
        reset_req_out ##1 !reset_req_out;
    endsequence

    chk_idle_stopped: assert property (
        (st.run == ITW_STOPPED && !wr_reload) |=> $stable(count))
        else $error("counter moved before start");
    chk_start_write: assert property (
        (wr_control && bus_req_in.wdata[BIT_START])
            |=> st.run == ITW_RUNNING)
        else $error("start write ignored");
    chk_never_halt: assert property (
        st.run == ITW_RUNNING |=> st.run == ITW_RUNNING)
        else $error("running watchdog halted");
    chk_reset_pulse: assert property (
        s_timeout |=> s_one_pulse)
        else $error("reset request not a single pulse");
    chk_pulse_cause: assert property (
        reset_req_out |-> $past(hit))
        else $error("spurious reset request");
    chk_flag_set: assert property (
        s_timeout |=> st.timeout_flag)
        else $error("timeout flag not set");
    chk_flag_sticky: assert property (
        (st.timeout_flag && !wr_status) |=> st.timeout_flag)
        else $error("timeout flag dropped");
    chk_flag_clear: assert property (
        (wr_status && !bus_req_in.wdata[BIT_TIMEOUT_FLAG] && !hit)
            |=> !st.timeout_flag)
        else $error("timeout flag not cleared");
    chk_status_read: assert property (
        (rd && bus_req_in.addr == OFS_STATUS)
            |=> rdata_out == {14'h0000, $past(st.run == ITW_RUNNING),
                $past(st.timeout_flag)})
        else $error("status read wrong");
    chk_capture_keep: assert property (
        (wr_capture && !wr_reload && st.run == ITW_RUNNING && !zero)
            |=> count == $past(count) - 32'h0000_0001)
        else $error("capture disturbed counting");
    chk_irq_level: assert property (
        (hit && st.interrupt_on_timeout_enable && !wr_control) |=> irq_out)
        else $error("interrupt level wrong");
endmodule

/* File: inc/itw_pkg.sv */
package itw_pkg;

    // ********************************
    // Register map, word offsets
    // ********************************
    localparam logic [2:0] OFS_STATUS = 3'h0;
    localparam logic [2:0] OFS_CONTROL = 3'h1;
    localparam logic [2:0] OFS_RELOAD_LO = 3'h2;
    localparam logic [2:0] OFS_RELOAD_HI = 3'h3;
    localparam logic [2:0] OFS_CAPTURE_LO = 3'h4;
    localparam logic [2:0] OFS_CAPTURE_HI = 3'h5;

    // ********************************
    // Field positions
    // ********************************
    localparam int BIT_TIMEOUT_FLAG = 0;
    localparam int BIT_RUNNING = 1;
    localparam int BIT_IRQ_ENABLE = 0;
    localparam int BIT_CONTINUOUS = 1;
    localparam int BIT_START = 2;
    localparam int BIT_STOP = 3;
    localparam int HALF_W = 16;

    // ********************************
    // Reset values
    // ********************************
    localparam logic [15:0] RST_RDATA = 16'h0000;
    localparam logic [31:0] RST_CAPTURE = 32'h0000_0000;

    // ********************************
    // Timing: watchdog timeout in ms at 8 ns clock
    // ********************************
    localparam int WDOG_TIMEOUT_MS = 1000;
    localparam int CLK_PERIOD_NS = 8;
    localparam int WDOG_CYCLES = WDOG_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
    // Counter sits at zero for one cycle, so reload is one short
    localparam logic [31:0] WDOG_RELOAD = 32'(WDOG_CYCLES - 1);

    // ********************************
    // Types
    // ********************************
    typedef enum logic {
        ITW_STOPPED,
        ITW_RUNNING
    } itw_run_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [2:0] addr;
        logic [15:0] wdata;
    } itw_bus_req_t;

    typedef struct packed {
        itw_run_t run;
        logic timeout_flag;
        logic interrupt_on_timeout_enable;
        logic continuous_select;
        logic [31:0] capture;
        logic [15:0] rdata;
        logic irq;
        logic reset_req;
    } itw_state_t;

    typedef struct packed {
        logic [31:0] count;
    } itw_cnt_state_t;

endpackage

/* File: design/itw_down_counter.sv */
module itw_down_counter #(
    parameter logic [31:0] RELOAD_VALUE = 32'h0000_0000
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic nrst_in,
    // Control
    input wire logic run_in,
    input wire logic reload_in,
    // Count state
    output logic [31:0] count_out,
    output logic zero_out
);
    import itw_pkg::*;

    itw_cnt_state_t st;
    itw_cnt_state_t next_st;

    // Reload wins; at zero the counter wraps back to the period
    always_comb begin
        next_st = st;
        if (reload_in) begin
            next_st.count = RELOAD_VALUE;
        end else if (run_in) begin
            if (st.count == 32'h0000_0000) begin
                next_st.count = RELOAD_VALUE;
            end else begin
                next_st.count = st.count - 32'h0000_0001;
            end
        end
    end

    // State register
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st.count <= RELOAD_VALUE;
        end else begin
            st <= next_st;
        end
    end

    assign count_out = st.count;
    assign zero_out = (st.count == 32'h0000_0000);

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);

    chk_hold_stopped: assert property (
        (!run_in && !reload_in) |=> $stable(count_out))
        else $error("counter moved while stopped");
    chk_reload_load: assert property (
        reload_in |=> count_out == RELOAD_VALUE)
        else $error("reload did not load period");
endmodule

/* File: testbench/itw_bus_master.sv */
module itw_bus_master (
    // Clock
    input wire logic core_clk_in,
    // Register port
    input wire logic [15:0] rdata_in,
    output itw_pkg::itw_bus_req_t bus_req_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import itw_pkg::*;

    initial bus_req_out = '0;

    // ********************************
    // Bus cycles, launched after the falling edge
    // ********************************
    // Released lines show inverted leftovers, never a stale match
    task automatic release_bus();
        bus_req_out.rd = 1'b0;
        bus_req_out.wr = 1'b0;
        bus_req_out.addr = ~bus_req_out.addr;
        bus_req_out.wdata = ~bus_req_out.wdata;
    endtask

    // One write; taken at the next rising edge, no wait state
    task automatic write_reg(input logic [2:0] a, input logic [15:0] d);
        @(negedge core_clk_in);
        bus_req_out = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge core_clk_in);
        @(negedge core_clk_in);
        release_bus();
    endtask

    // One read; data stands only in the cycle after the strobe
    task automatic read_reg(input logic [2:0] a, output logic [15:0] d);
        @(negedge core_clk_in);
        bus_req_out = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
        @(posedge core_clk_in);
        @(negedge core_clk_in);
        d = rdata_in;
        release_bus();
    endtask
endmodule

/* File: testbench/test_interval_timer_watchdog.sv */
module test_interval_timer_watchdog;
    timeunit 1ns;
    timeprecision 1ps;
    import itw_pkg::*;

    // Short reload keeps the run brief
    localparam logic [31:0] RLD = 32'h0000_0014;
    logic core_clk_in = 1'b0;
    logic nrst_in = 1'b0;
    itw_bus_req_t bus_req;
    logic [15:0] rdata;
    logic irq;
    logic rst_req;
    logic prev_req = 1'b0;
    logic [15:0] rv;
    logic [31:0] lfsr = 32'd77489;
    int mismatches = 0;
    int n_compared = 0;
    int cyc = 0;
    int pulses[$];
    int base_pulses = 0;

    always #4 core_clk_in = ~core_clk_in;

    itw_bus_master u_bm (.core_clk_in(core_clk_in), .rdata_in(rdata),
        .bus_req_out(bus_req));
    itw_watchdog #(.RELOAD_VALUE(RLD), .READABLE_CAPTURE(1'b0)) u_dut (
        .core_clk_in(core_clk_in), .nrst_in(nrst_in), .bus_req_in(bus_req),
        .rdata_out(rdata), .irq_out(irq), .reset_req_out(rst_req));

    // ********************************
    // Helpers
    // ********************************
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [15:0] exp_status(input logic r, input logic f);
        return {14'h0000, r, f};
    endfunction

    // Fixed period halves; capture and unmapped places read zero
    function automatic logic [15:0] exp_map(input logic [2:0] a);
        if (a == OFS_RELOAD_LO) return RLD[15:0];
        if (a == OFS_RELOAD_HI) return RLD[31:16];
        return 16'h0000;
    endfunction

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic wait_pulses(input int n);
        for (int i = 0; i < 100 && pulses.size() < n; i++)
            @(posedge core_clk_in);
    endtask

    task automatic give_verdict();
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Records request pulses mid-cycle, where the flop output has settled
    always @(negedge core_clk_in) begin
        cyc <= cyc + 1;
        prev_req <= rst_req;
        if (rst_req === 1'b1)
            pulses.push_back(cyc);
        if (rst_req === 1'b1 && prev_req === 1'b1)
            check("pulse_width", 32'h1, 32'h0);
    end

    // Hang guard, well past the expected run length
    initial begin
        repeat (5000) @(posedge core_clk_in);
        mismatches++;
        give_verdict();
    end

    // ********************************
    // Main sequence
    // ********************************
    initial begin
        repeat (5) @(posedge core_clk_in);
        @(negedge core_clk_in);
        nrst_in = 1'b1;
        repeat (30) @(posedge core_clk_in);
        u_bm.read_reg(OFS_STATUS, rv);
        check("status_idle", rv, exp_status(1'b0, 1'b0));
        check("idle_pulses", 32'(pulses.size()), 32'h0);
        for (int a = 2; a < 8; a++) begin
            u_bm.read_reg(3'(a), rv);
            check("map_read", rv, exp_map(3'(a)));
        end
        // Every irq-enable/continuous code, stop bit set, start bit clear
        for (int v = 0; v < 4; v++) begin
            u_bm.write_reg(OFS_CONTROL, 16'(v) | 16'h0008);
            u_bm.read_reg(OFS_CONTROL, rv);
            check("control", rv, 16'(v));
        end
        u_bm.write_reg(OFS_RELOAD_LO, lfsr[15:0]);
        u_bm.read_reg(OFS_STATUS, rv);
        check("kick_stopped", rv, exp_status(1'b0, 1'b0));
        u_bm.write_reg(OFS_CONTROL, 16'h0007);
        u_bm.read_reg(OFS_STATUS, rv);
        check("started", rv, exp_status(1'b1, 1'b0));
        // Random kicks, each inside the timeout span
        for (int k = 0; k < 8; k++) begin
            lfsr = next_rand(lfsr);
            repeat (lfsr[3:0] % 10) @(posedge core_clk_in);
            u_bm.write_reg(lfsr[4] ? OFS_RELOAD_HI : OFS_RELOAD_LO,
                           lfsr[31:16]);
        end
        check("kicked_pulses", 32'(pulses.size()), 32'h0);
        u_bm.read_reg(OFS_RELOAD_HI, rv);
        check("period_fixed", rv, RLD[31:16]);
        u_bm.write_reg(OFS_CONTROL, 16'h0009);
        wait_pulses(1);
        check("first_pulse", 32'(pulses.size()), 32'h1);
        u_bm.write_reg(OFS_CAPTURE_HI, lfsr[15:0]);
        wait_pulses(2);
        check("pulse_gap", 32'(pulses[1] - pulses[0]),
              RLD + 32'h1);
        u_bm.read_reg(OFS_STATUS, rv);
        check("flag_sticky", rv, exp_status(1'b1, 1'b1));
        check("irq_on", 32'(irq), 32'h1);
        // Status write with bit 0 set must leave the flag alone
        u_bm.write_reg(OFS_STATUS, lfsr[31:16] | 16'h0001);
        u_bm.read_reg(OFS_STATUS, rv);
        check("flag_kept", rv, exp_status(1'b1, 1'b1));
        u_bm.write_reg(OFS_STATUS, lfsr[31:16] & 16'hfffe);
        u_bm.read_reg(OFS_STATUS, rv);
        check("flag_clear", rv, exp_status(1'b1, 1'b0));
        check("irq_off", 32'(irq), 32'h0);
        // Mid-run reset: only a reset ends the run, and it comes back stopped
        @(negedge core_clk_in);
        nrst_in = 1'b0;
        repeat (5) @(negedge core_clk_in);
        nrst_in = 1'b1;
        base_pulses = pulses.size();
        repeat (2 * int'(RLD)) @(posedge core_clk_in);
        check("reset_pulses", 32'(pulses.size()),
              32'(base_pulses));
        u_bm.read_reg(OFS_STATUS, rv);
        check("reset_status", rv, exp_status(1'b0, 1'b0));
        check("reset_irq", 32'(irq), 32'h0);
        give_verdict();
    end
endmodule
